// *** rtl/vsmcd_top.sv ***
/*
 * VME slave decode: shared-window location monitors and translation of
 * configuration-space slave image hits into PCI configuration requests.
 * Assumes VME pins arrive unsynchronised, the PCI side answers a request
 * with a one-cycle cfg_done on hclk, and one AHB-Lite master.
 */
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "vsmcd_params.svh"

module vsmcd_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic vme_as_n,
	input wire logic vme_ds_n,
	input wire logic vme_write_n,
	input wire logic [5:0] vme_am,
	input wire logic [31:1] vme_addr,
	input wire logic own_master,
	output logic vme_dtack_n_o,
	output logic vme_dtack_oe,
	output logic [3:0] monitor_irq,
	output logic cfg_req,
	output logic cfg_type1,
	output logic cfg_write,
	output logic [31:0] cfg_addr,
	input wire logic cfg_done
);
	import vsmcd_pkg::*;

	// space of an address modifier; block and unknown codes give none
	function automatic vsmcd_space_t am_space(input logic [5:0] am);
		if (am[1:0] == 2'h1 || am[1:0] == 2'h2) begin
			unique case (am[5:3])
				3'h5: am_space = (am[1:0] == 2'h1) ? VSMCD_A16 : VSMCD_NONE;
				3'h7: am_space = VSMCD_A24;
				3'h1: am_space = VSMCD_A32;
				default: am_space = VSMCD_NONE;
			endcase
		end else begin
			am_space = VSMCD_NONE;
		end
	endfunction

	// clear address bits that lie above the width of the space
	function automatic logic [31:0] space_mask(input logic [31:0] a,
			input logic [3:0] vas);
		unique case (vas)
			VSMCD_A16: space_mask = {16'h0000, a[15:0]};
			VSMCD_A24: space_mask = {8'h00, a[23:0]};
			default: space_mask = a;
		endcase
	endfunction

	// one-hot device select; codes past the last line select nothing
	function automatic logic [20:0] dev_line(input logic [4:0] dev);
		dev_line = 21'h000000;
		if (dev <= `VSMCD_DEV_MAX) begin
			dev_line[dev] = 1'b1;
		end
	endfunction

	logic [1:0] as_sync_q, ds_sync_q, wr_sync_q;
	logic [5:0] am_s1_q, am_s2_q;
	logic [31:1] addr_s1_q, addr_s2_q;
	logic [31:0] mon_ctl_q, mon_base_q, master_ctl_q;
	logic [31:0] si_ctl_q, si_base_q, si_bound_q, si_offset_q;
	logic [3:0] pending_q;
	logic [3:0] mon_set, mon_clr;
	logic [31:0] cfg_addr_d;
	logic [31:0] va, va_sum, va_m, base_m;
	logic cycle_on, mon_hit, si_hit, bus_match;
	logic space_ok, pgm_ok, super_ok, base_ok;
	vsmcd_space_t acc_space;
	vsmcd_state_t state_q, state_d;
	logic dwr_q;
	logic [7:0] dofs_q;
	logic [31:0] rdata_d;

	// every VME pin passes two flops before any decode reads it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			as_sync_q <= 2'h3;
			ds_sync_q <= 2'h3;
			wr_sync_q <= 2'h3;
		end else begin
			as_sync_q <= {as_sync_q[0], vme_as_n};
			ds_sync_q <= {ds_sync_q[0], vme_ds_n};
			wr_sync_q <= {wr_sync_q[0], vme_write_n};
		end
	end

	// address and modifier are only decoded once both strobes are seen,
	// so a bit caught while changing is never used
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			am_s1_q <= 6'h00;
			am_s2_q <= 6'h00;
			addr_s1_q <= 31'h00000000;
			addr_s2_q <= 31'h00000000;
		end else begin
			am_s1_q <= vme_am;
			am_s2_q <= am_s1_q;
			addr_s1_q <= vme_addr;
			addr_s2_q <= addr_s1_q;
		end
	end

	// address and strobes may skew; decode waits for both strobes
	assign cycle_on = !as_sync_q[1] && !ds_sync_q[1];
	assign va = {addr_s2_q, 1'b0};
	assign acc_space = am_space(am_s2_q);

	// both sides of the window compare are cut to the width of the space
	assign va_m = space_mask(va, acc_space);
	assign base_m = space_mask(mon_base_q, acc_space);
	assign space_ok = acc_space == mon_ctl_q[`VSMCD_VAS_HI:`VSMCD_VAS_LO];
	assign pgm_ok = mon_ctl_q[`VSMCD_PGM_LO + (am_s2_q[1] ? 1 : 0)];
	assign super_ok = mon_ctl_q[`VSMCD_SUPER_LO + (am_s2_q[2] ? 1 : 0)];
	assign base_ok = va_m[31:12] == base_m[31:12];

	// one shared control and base decode the whole 4-Kbyte window
	always_comb begin
		mon_hit = mon_ctl_q[`VSMCD_CTL_EN] &&
			acc_space != VSMCD_NONE &&
			space_ok && pgm_ok && super_ok &&
			base_ok;
	end

	// configuration-space slave image decode
	always_comb begin
		si_hit = si_ctl_q[`VSMCD_CTL_EN] &&
			si_ctl_q[`VSMCD_LAS_HI:`VSMCD_LAS_LO] == `VSMCD_LAS_CFG &&
			acc_space != VSMCD_NONE &&
			acc_space == si_ctl_q[`VSMCD_VAS_HI:`VSMCD_VAS_LO] &&
			va_m >= si_base_q &&
			va_m < si_bound_q;
	end

	assign va_sum = va + si_offset_q;
	// bus number is taken from the untranslated VME address
	assign bus_match = va[23:16] ==
		master_ctl_q[`VSMCD_BUSNO_HI:`VSMCD_BUSNO_LO];

	// type 0 keeps only register, function and device select
	always_comb begin
		if (bus_match) begin
			cfg_addr_d = {dev_line(va_sum[15:11]),
				va_sum[10:8], va_sum[7:2], 2'h0};
		end else begin
			cfg_addr_d = {va_sum[31:2], 2'h1};
		end
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			VSMCD_IDLE: begin
				if (cycle_on) begin
					state_d = VSMCD_DECODE;
				end
			end
			VSMCD_DECODE: begin
				if (!cycle_on) begin
					state_d = VSMCD_IDLE;
				end else if (mon_hit && own_master) begin
					state_d = VSMCD_ACK;
				end else if (si_hit && !mon_hit) begin
					state_d = VSMCD_CFG_WAIT;
				end else begin
					state_d = VSMCD_WAIT_END;
				end
			end
			VSMCD_CFG_WAIT: begin
				if (cfg_done) begin
					state_d = VSMCD_ACK;
				end
			end
			VSMCD_ACK: begin
				if (as_sync_q[1]) begin
					state_d = VSMCD_IDLE;
				end
			end
			VSMCD_WAIT_END: begin
				if (as_sync_q[1]) begin
					state_d = VSMCD_IDLE;
				end
			end
			default: state_d = VSMCD_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= VSMCD_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// open-drain dtack: drive low only while acknowledging
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vme_dtack_oe <= 1'b0;
			vme_dtack_n_o <= 1'b1;
		end else begin
			vme_dtack_oe <= state_d == VSMCD_ACK;
			vme_dtack_n_o <= state_d != VSMCD_ACK;
		end
	end

	// request held from decode until the PCI side reports done
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_req <= 1'b0;
			cfg_type1 <= 1'b0;
			cfg_write <= 1'b0;
			cfg_addr <= `VSMCD_RST_ZERO;
		end else if (state_q == VSMCD_DECODE &&
				state_d == VSMCD_CFG_WAIT) begin
			cfg_req <= 1'b1;
			cfg_type1 <= !bus_match;
			cfg_write <= !wr_sync_q[1];
			cfg_addr <= cfg_addr_d;
		end else if (cfg_done) begin
			cfg_req <= 1'b0;
		end
	end

	// no data is latched on a hit; only the pending bit moves
	always_comb begin
		mon_set = 4'h0;
		if (state_q == VSMCD_DECODE && cycle_on && mon_hit) begin
			mon_set[va[4:3]] = 1'b1;
		end
	end

	always_comb begin
		mon_clr = 4'h0;
		if (dwr_q && dofs_q == `VSMCD_OFS_STATUS) begin
			mon_clr = hwdata[3:0];
		end
	end

	// a hit in the clearing cycle survives the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pending_q <= 4'h0;
		end else begin
			pending_q <= (pending_q & ~mon_clr) | mon_set;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			monitor_irq <= 4'h0;
		end else begin
			monitor_irq <= (pending_q & ~mon_clr) | mon_set;
		end
	end

	// AHB-Lite: zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dwr_q <= 1'b0;
			dofs_q <= 8'h00;
		end else if (hready) begin
			dwr_q <= hsel && htrans[1] && hwrite;
			dofs_q <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// the four monitors share this one pair of settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mon_ctl_q <= `VSMCD_RST_ZERO;
			mon_base_q <= `VSMCD_RST_ZERO;
		end else if (dwr_q && dofs_q == `VSMCD_OFS_MON_CTL) begin
			mon_ctl_q <= hwdata;
		end else if (dwr_q && dofs_q == `VSMCD_OFS_MON_BASE) begin
			mon_base_q <= {hwdata[31:12], 12'h000};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			master_ctl_q <= `VSMCD_RST_ZERO;
			si_ctl_q <= `VSMCD_RST_ZERO;
			si_base_q <= `VSMCD_RST_ZERO;
			si_bound_q <= `VSMCD_RST_BOUND;
			si_offset_q <= `VSMCD_RST_ZERO;
		end else if (dwr_q) begin
			unique case (dofs_q)
				`VSMCD_OFS_MASTER_CTL: master_ctl_q <= hwdata;
				`VSMCD_OFS_SI_CTL: si_ctl_q <= hwdata;
				`VSMCD_OFS_SI_BASE: si_base_q <= hwdata;
				`VSMCD_OFS_SI_BOUND: si_bound_q <= hwdata;
				`VSMCD_OFS_SI_OFFSET: si_offset_q <= hwdata;
				default: ;
			endcase
		end
	end

	// read data prepared in the address phase, shown in the data phase;
	// a write ahead of a read to the same word is seen one read late
	always_comb begin
		unique case (haddr[7:0])
			`VSMCD_OFS_MON_CTL: rdata_d = mon_ctl_q;
			`VSMCD_OFS_MON_BASE: rdata_d = mon_base_q;
			`VSMCD_OFS_MASTER_CTL: rdata_d = master_ctl_q;
			`VSMCD_OFS_SI_CTL: rdata_d = si_ctl_q;
			`VSMCD_OFS_SI_BASE: rdata_d = si_base_q;
			`VSMCD_OFS_SI_BOUND: rdata_d = si_bound_q;
			`VSMCD_OFS_SI_OFFSET: rdata_d = si_offset_q;
			`VSMCD_OFS_STATUS: rdata_d = {25'h0, state_q, pending_q};
			`VSMCD_OFS_CFG_ADDR: rdata_d = cfg_addr;
			default: rdata_d = `VSMCD_RST_ZERO;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= `VSMCD_RST_ZERO;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= rdata_d;
		end
	end

endmodule

`default_nettype wire

// *** rtl/vsmcd_params.svh ***
/*
 * Constants for the VME slave monitor and configuration decoder:
 * register offsets, field positions and reset values.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef VSMCD_PARAMS_SVH
`define VSMCD_PARAMS_SVH

`define VSMCD_OFS_MON_CTL 8'h00
`define VSMCD_OFS_MON_BASE 8'h04
`define VSMCD_OFS_MASTER_CTL 8'h08
`define VSMCD_OFS_SI_CTL 8'h0c
`define VSMCD_OFS_SI_BASE 8'h10
`define VSMCD_OFS_SI_BOUND 8'h14
`define VSMCD_OFS_SI_OFFSET 8'h18
`define VSMCD_OFS_STATUS 8'h1c
`define VSMCD_OFS_CFG_ADDR 8'h20

`define VSMCD_CTL_EN 31
`define VSMCD_PGM_HI 23
`define VSMCD_PGM_LO 22
`define VSMCD_SUPER_HI 21
`define VSMCD_SUPER_LO 20
`define VSMCD_VAS_HI 19
`define VSMCD_VAS_LO 16
`define VSMCD_LAS_HI 1
`define VSMCD_LAS_LO 0
`define VSMCD_BUSNO_HI 15
`define VSMCD_BUSNO_LO 8

`define VSMCD_LAS_CFG 2'h2
`define VSMCD_RST_ZERO 32'h0000_0000
`define VSMCD_RST_BOUND 32'h0000_0000
`define VSMCD_DEV_MAX 5'h14

`endif

// *** rtl/vsmcd_pkg.sv ***
/*
 * Types for the VME slave monitor and configuration decoder.
 * Assumes vsmcd_params.svh is on the include path.
 */
`include "vsmcd_params.svh"

package vsmcd_pkg;

	typedef enum logic [2:0] {
		VSMCD_IDLE = 3'h0,
		VSMCD_DECODE = 3'h1,
		VSMCD_CFG_WAIT = 3'h3,
		VSMCD_ACK = 3'h2,
		VSMCD_WAIT_END = 3'h6
	} vsmcd_state_t;

	typedef enum logic [3:0] {
		VSMCD_A16 = 4'h0,
		VSMCD_A24 = 4'h1,
		VSMCD_A32 = 4'h2,
		VSMCD_NONE = 4'hf
	} vsmcd_space_t;

endpackage

// *** bench/vsmcd_asserts.sv ***
/* checker for vsmcd_top: dtack, config requests, monitor irqs.
   assumes bind to vsmcd_top ports, one clock hclk. */
`timescale 1ns/10ps
`default_nettype none
module vsmcd_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic vme_as_n,
	input wire logic own_master,
	input wire logic vme_dtack_n_o,
	input wire logic vme_dtack_oe,
	input wire logic [3:0] monitor_irq,
	input wire logic cfg_req,
	input wire logic cfg_type1,
	input wire logic [31:0] cfg_addr,
	input wire logic cfg_done
);
	logic [3:0] irq_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) irq_q <= 4'h0;
		else irq_q <= monitor_irq;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence cfg_hs;
		cfg_req && cfg_done;
	endsequence
	sequence irq_new;
		|(monitor_irq & ~irq_q);
	endsequence
	dtack_own_a: assert property ($rose(vme_dtack_oe) |->
		own_master || $past(cfg_done)) else $error("dtack not own");
	dtack_low_a: assert property (vme_dtack_oe |-> !vme_dtack_n_o)
		else $error("dtack level wrong");
	// release bound covers the two-flop strobe sync
	dtack_free_a: assert property ($rose(vme_as_n) |->
		##[1:5] !vme_dtack_oe) else $error("dtack held");
	cfg_end_a: assert property (cfg_hs |=> !cfg_req && vme_dtack_oe)
		else $error("config end wrong");
	cfg_hold_a: assert property (cfg_req && $past(cfg_req) |->
		$stable(cfg_addr) && $stable(cfg_type1)) else $error("cfg moved");
	type0_line_a: assert property (cfg_req && !cfg_type1 |->
		$onehot(cfg_addr[31:11]) && cfg_addr[1:0] == 2'h0)
		else $error("type0 address wrong");
	type1_code_a: assert property (cfg_req && cfg_type1 |->
		cfg_addr[1:0] == 2'h1) else $error("type1 code wrong");
	irq_cause_a: assert property (irq_new |-> !$past(vme_as_n, 2))
		else $error("irq without access");
endmodule
bind vsmcd_top vsmcd_asserts chk_u (.hclk, .hresetn, .vme_as_n,
	.own_master, .vme_dtack_n_o, .vme_dtack_oe, .monitor_irq, .cfg_req,
	.cfg_type1, .cfg_addr, .cfg_done);
`default_nettype wire

// *** bench/vsmcd_pci_model.sv ***
/* pci config target model: raises cfg_done lat+1 cycles after cfg_req rises.
   assumes one outstanding request on hclk. */
`timescale 1ns/10ps
`default_nettype none
module vsmcd_pci_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic cfg_req,
	input wire logic [3:0] lat,
	output logic cfg_done
);
	logic [3:0] cnt_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 4'h0;
			cfg_done <= 1'b0;
		end else begin
			cnt_q <= (cfg_req && !cfg_done) ? cnt_q + 4'h1 : 4'h0;
			cfg_done <= cfg_req && !cfg_done && cnt_q == lat;
		end
	end
endmodule
`default_nettype wire

// *** bench/vsmcd_top_tb.sv ***
/* bench for vsmcd_top: registers, location monitors, config requests.
   assumes the pci model ends each config request. */
`timescale 1ns/10ps
`default_nettype none
module vsmcd_top_tb;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ack;
	logic vme_as_n, vme_ds_n, vme_write_n, own_master, vme_dtack_n_o;
	logic vme_dtack_oe, cfg_req, cfg_type1, cfg_write, cfg_done;
	logic [31:0] haddr, hwdata, hrdata, cfg_addr, rd;
	logic [1:0] htrans;
	logic [5:0] vme_am;
	logic [31:1] vme_addr;
	logic [3:0] monitor_irq, lat;
	int err_count, num_checks;
	vsmcd_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
		.hresp, .vme_as_n, .vme_ds_n, .vme_write_n, .vme_am, .vme_addr,
		.own_master, .vme_dtack_n_o, .vme_dtack_oe, .monitor_irq, .cfg_req,
		.cfg_type1, .cfg_write, .cfg_addr, .cfg_done);
	vsmcd_pci_model pci_u (.hclk, .hresetn, .cfg_req, .lat, .cfg_done);
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	task stop_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask
	task ahb(input logic w, input logic [31:0] a, d);
		@(posedge hclk);
		hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	// released address lines show the inverse, never the last value
	task vme(input logic [31:0] a, input logic [5:0] am, input logic own);
		@(posedge hclk);
		vme_addr <= a[31:1]; vme_am <= am; own_master <= own;
		vme_as_n <= 1'b0; vme_ds_n <= 1'b0; vme_write_n <= 1'b0;
		ack = 1'b0;
		for (int i = 0; i < 40 && !ack; i++) begin
			@(posedge hclk);
			ack = vme_dtack_oe === 1'b1;
		end
		vme_as_n <= 1'b1; vme_ds_n <= 1'b1; vme_addr <= ~a[31:1];
		repeat (6) @(posedge hclk);
	endtask
	task t_regs;
		ahb(1'b0, 32'h0, 32'h0);
		chk("ctl_rst", 32'h0, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
		ahb(1'b1, 32'h4, 32'h1234_5fff);
		ahb(1'b0, 32'h4, 32'h0);
		chk("base", 32'h1234_5000, rd);
		ahb(1'b1, 32'h24, 32'hffff_ffff);
		ahb(1'b0, 32'h24, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("test regs done");
	endtask
	task t_mon;
		ahb(1'b1, 32'h0, 32'h80f2_0000);
		for (int i = 0; i < 4; i++) begin
			vme(32'h1234_5000 + 32'(i * 8), 6'h09, i[0]);
			chk("dtack", {31'h0, i[0]}, {31'h0, ack});
			chk("irq", 32'(4'hf >> (3 - i)), {28'h0, monitor_irq});
		end
		ahb(1'b0, 32'h1c, 32'h0);
		chk("pending", 32'hf, {28'h0, rd[3:0]});
		ahb(1'b1, 32'h1c, 32'hf);
		repeat (2) @(posedge hclk);
		chk("cleared", 32'h0, {28'h0, monitor_irq});
		$display("test monitors done");
	endtask
	task t_miss;
		logic [31:0] c [6];
		logic [31:0] ad [6];
		logic [5:0] am [6];
		c = '{32'h80f2_0000, 32'h80f2_0000, 32'h80f2_0000, 32'h8052_0000,
			32'h8052_0000, 32'h00f2_0000};
		ad = '{32'h1234_6000, 32'h1234_5000, 32'h1234_5000, 32'h1234_5000,
			32'h1234_5000, 32'h1234_5000};
		am = '{6'h09, 6'h0b, 6'h39, 6'h0d, 6'h0a, 6'h09};
		for (int i = 0; i < 6; i++) begin
			ahb(1'b1, 32'h0, c[i]);
			vme(ad[i], am[i], 1'b1);
			chk("miss", 32'h0, {27'h0, ack, monitor_irq});
		end
		ahb(1'b1, 32'h0, 32'h80f1_0000);
		vme(32'hab34_5018, 6'h39, 1'b0);
		chk("a24", 32'h8, {27'h0, ack, monitor_irq});
		ahb(1'b1, 32'h1c, 32'hf);
		ahb(1'b1, 32'h0, 32'h0);
		$display("test misses done");
	endtask
	task t_cfg;
		ahb(1'b1, 32'h0c, 32'h8002_0002);
		ahb(1'b1, 32'h10, 32'h4000_0000);
		ahb(1'b1, 32'h14, 32'h8000_0000);
		ahb(1'b1, 32'h18, 32'h0);
		ahb(1'b1, 32'h08, 32'h0000_0500);
		for (int d = 0; d <= 20; d++) begin
			vme(32'h4005_037c | 32'(d << 11), 6'h09, 1'b0);
			chk("t0", (32'h1 << (11 + d)) | 32'h37c, cfg_addr);
			chk("t0_kind", 32'h5, {29'h0, ack, cfg_type1, cfg_write});
		end
		lat <= 4'h9;
		vme(32'h4106_a37c, 6'h09, 1'b0);
		chk("t1", 32'h4106_a37d, cfg_addr);
		chk("t1_kind", 32'h7, {29'h0, ack, cfg_type1, cfg_write});
		ahb(1'b1, 32'h18, 32'h0100_0000);
		vme(32'h4106_0004, 6'h09, 1'b0);
		chk("sum", 32'h4206_0005, cfg_addr);
		ahb(1'b0, 32'h20, 32'h0);
		chk("cfg_rd", 32'h4206_0005, rd);
		$display("test config done");
	endtask
	initial begin
		#100000;
		err_count++;
		stop_test;
	end
	initial begin
		hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
		hwrite = 1'b0; hwdata = 32'h0; vme_as_n = 1'b1; vme_ds_n = 1'b1;
		vme_write_n = 1'b1; vme_am = 6'h0; vme_addr = 31'h0;
		own_master = 1'b0; lat = 4'h2; err_count = 0; num_checks = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_mon;
		t_miss;
		t_cfg;
		stop_test;
	end
endmodule
`default_nettype wire
